// >>> hdl/scf_pkg.sv
// Shared constants and types for the command frame serial slave
package scf_pkg;

  localparam int FRAME_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int MIN_BYTES = FRAME_BITS / BYTE_BITS;

  // Command prefixes (top two bits) and read and diagnosis trailers (bottom two bits)
  localparam logic [1:0] PFX_WRITE = 2'h2;
  localparam logic [1:0] PFX_WRITE_BAD = 2'h3;
  localparam logic [1:0] PFX_READ = 2'h1;
  localparam logic [1:0] TRL_READ = 2'h2;
  localparam logic [1:0] TRL_DIAG = 2'h1;

  // Register locations: bank address field and register index field
  localparam logic [3:0] BANK_OUT = 4'h0;
  localparam logic [3:0] BANK_MAP = 4'h1;
  localparam logic [1:0] IDX_OUT = 2'h0;
  localparam logic [1:0] IDX_MAP0 = 2'h0;
  localparam logic [1:0] IDX_MAP1 = 2'h1;
  localparam logic [1:0] IDX_INPUT_STATUS_REGISTER = 2'h2;

  // Register slots: three in the writable register array, plus the read-only input status slot
  localparam int NUM_WREGS = 3;
  localparam logic [1:0] SLOT_OUT = 2'h0;
  localparam logic [1:0] SLOT_MAP0 = 2'h1;
  localparam logic [1:0] SLOT_MAP1 = 2'h2;
  localparam logic [1:0] SLOT_INPUT_STATUS_REGISTER = 2'h3;

  // Values after reset
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_MAP0 = 8'h04;
  localparam logic [7:0] RST_MAP1 = 8'h08;

  // Reply sent after a command syntax error
  localparam logic [15:0] SYNTAX_REPLY = 16'hBFFF;

  // Pin vector layout: {sclk, chip_select_low, si}, idle levels at reset
  localparam int PIN_SCLK = 2;
  localparam int PIN_CS = 1;
  localparam int PIN_SI = 0;
  localparam logic [2:0] PIN_RST = 3'h2;

  typedef struct packed {
    logic sclk;
    logic chip_select_low;
    logic si;
  } scf_pins_t;

  typedef struct packed {
    logic uv_supply;
    logic low_logic_supply;
    logic [1:0] mode;
    logic open_load_off;
    logic [7:0] chan_err;
  } scf_diag_t;

  typedef struct packed {
    logic [7:0] out_ctrl;
    logic [7:0] map_in0;
    logic [7:0] map_in1;
  } scf_ctrl_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SHIFT = 2'b10
  } scf_state_t;

endpackage : scf_pkg

// >>> hdl/scf_pin_filter.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module scf_pin_filter #(
  parameter int W = 3,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] level
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
  } scf_filt_t;

  scf_filt_t st_r;
  scf_filt_t st_nxt;

  always_comb begin
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    // Stage one feeds only stage two; level moves once stages two and three agree
    st_nxt.lvl = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.lvl);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign level = st_r.lvl;

endmodule : scf_pin_filter
`default_nettype wire

// >>> hdl/scf_slave.sv
// Serial command frame slave: shifts frames, decodes commands, answers next frame
// What this block does
// - Reply to a command goes out only in the next frame, never the same one.
// - Clock count not a multiple of 8 or below 16 gives a transfer-error reply.
// - After power-on or software reset the first reply is the reset response.
// - Write with prefix 11 is a syntax error, answered by syntax reply next frame.
// - Read with prefix 00 is a syntax error, answered by syntax reply next frame.
// - Access to reserved or unused location is a syntax error, content never sent.
// - Write 10,bank,index,data stores data and answers standard diagnosis, MSB zero.
// - Read 01,bank,index,x,10 answers 10, same address fields, 8-bit content.
// - Serial input is sampled on the falling serial clock edge.
// - Output released while deselected, MSB first, new bit after rising clock edge.
// - Frame is accepted and acted on only at the rising chip select edge.
// - First reply after reset has error flag and input status; next clears it.
`timescale 1ns/1ns
`default_nettype none
module scf_slave
  import scf_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire scf_pins_t pins,
  input wire logic soft_reset,
  input wire scf_diag_t diag,
  input wire logic [6:0] input_status,
  output logic so_out,
  output logic so_oe,
  output scf_ctrl_t ctrl
);

  typedef struct packed {
    scf_state_t st;
    logic sclk_q;
    logic cs_q;
    logic [FRAME_BITS-1:0] sr;
    logic si_smp;
    logic [2:0] bit_lo;
    logic [1:0] bytes;
    logic rst_pend;
    logic std_pend;
    logic transfer_error_flag;
    logic [FRAME_BITS-1:0] reply;
    logic [NUM_WREGS-1:0][7:0] regs;
    logic so;
    logic oe;
  } scf_slave_t;

  scf_slave_t st_r;
  scf_slave_t st_nxt;
  logic [2:0] pin_lvl;
  logic sclk;
  logic cs_low;
  logic si;

  scf_pin_filter #(
    .W(3),
    .RST_VAL(PIN_RST)
  ) u_filter (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pin_in({pins.sclk, pins.chip_select_low, pins.si}),
    .level(pin_lvl)
  );

  assign sclk = pin_lvl[PIN_SCLK];
  assign cs_low = pin_lvl[PIN_CS];
  assign si = pin_lvl[PIN_SI];

  // Map bank/index to a slot; ok low means reserved or unused
  function automatic logic [2:0] scf_lookup(input logic [3:0] bank, input logic [1:0] idx);
    logic [2:0] r;
    r = 3'h0;
    if (bank == BANK_OUT && idx == IDX_OUT) begin
      r = {1'b1, SLOT_OUT};
    end else if (bank == BANK_MAP && idx == IDX_MAP0) begin
      r = {1'b1, SLOT_MAP0};
    end else if (bank == BANK_MAP && idx == IDX_MAP1) begin
      r = {1'b1, SLOT_MAP1};
    end else if (bank == BANK_MAP && idx == IDX_INPUT_STATUS_REGISTER) begin
      r = {1'b1, SLOT_INPUT_STATUS_REGISTER};
    end
    return r;
  endfunction : scf_lookup

  logic sclk_fall;
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic [FRAME_BITS-1:0] cmd;
  logic [FRAME_BITS-1:0] std_frame;
  logic [FRAME_BITS-1:0] rst_frame;
  logic [7:0] input_status_register_val;
  logic [2:0] loc;
  logic [7:0] rd_val;
  logic frame_ok;

  always_comb begin
    sclk_fall = st_r.sclk_q & ~sclk;
    sclk_rise = ~st_r.sclk_q & sclk;
    cs_fall = st_r.cs_q & ~cs_low;
    cs_rise = ~st_r.cs_q & cs_low;
    // Last sampled bit has no rising edge after it, so append it here
    cmd = {st_r.sr[FRAME_BITS-2:0], st_r.si_smp};
    input_status_register_val = {st_r.transfer_error_flag, input_status};
    std_frame = {1'b0, diag.uv_supply, diag.low_logic_supply, diag.mode, st_r.transfer_error_flag, 1'b0,
                 diag.open_load_off, diag.chan_err};
    rst_frame = {PFX_WRITE, BANK_MAP, IDX_INPUT_STATUS_REGISTER, input_status_register_val};
    loc = scf_lookup(cmd[13:10], cmd[9:8]);
    // Input status has no slot in the register array, so it is picked here
    case (loc[1:0])
      SLOT_OUT: rd_val = st_r.regs[SLOT_OUT];
      SLOT_MAP0: rd_val = st_r.regs[SLOT_MAP0];
      SLOT_MAP1: rd_val = st_r.regs[SLOT_MAP1];
      default: rd_val = input_status_register_val;
    endcase
    // Byte count saturates at two, so every longer multiple of eight passes
    frame_ok = (st_r.bit_lo == 3'h0) && (st_r.bytes == 2'(MIN_BYTES));

    st_nxt = st_r;
    st_nxt.sclk_q = sclk;
    st_nxt.cs_q = cs_low;

    case (st_r.st)
      ST_IDLE: begin
        st_nxt.oe = 1'b0;
        if (cs_fall) begin
          // Reply loaded here belongs to the previous frame
          if (st_r.rst_pend) begin
            st_nxt.sr = rst_frame;
          end else if (st_r.std_pend) begin
            st_nxt.sr = std_frame;
          end else begin
            st_nxt.sr = st_r.reply;
          end
          st_nxt.so = st_nxt.sr[FRAME_BITS-1];
          st_nxt.oe = 1'b1;
          st_nxt.rst_pend = 1'b0;
          st_nxt.bit_lo = 3'h0;
          st_nxt.bytes = 2'h0;
          st_nxt.st = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (sclk_fall) begin
          st_nxt.si_smp = si;
          st_nxt.bit_lo = st_r.bit_lo + 3'h1;
          if (st_r.bit_lo == 3'h7 && st_r.bytes != 2'(MIN_BYTES)) begin
            st_nxt.bytes = st_r.bytes + 2'h1;
          end
        end
        // No shift before the first sample: MSB is already on the pin
        if (sclk_rise && (st_r.bit_lo != 3'h0 || st_r.bytes != 2'h0)) begin
          st_nxt.sr = cmd;
          st_nxt.so = st_r.sr[FRAME_BITS-2];
        end
        if (cs_rise) begin
          st_nxt.oe = 1'b0;
          st_nxt.st = ST_IDLE;
          st_nxt.std_pend = 1'b0;
          // Anything not decoded below is answered as a syntax error
          st_nxt.reply = SYNTAX_REPLY;
          st_nxt.transfer_error_flag = ~frame_ok;
          if (!frame_ok) begin
            st_nxt.std_pend = 1'b1;
          end else if (cmd[15:14] == PFX_WRITE) begin
            if (loc[2] && loc[1:0] != SLOT_INPUT_STATUS_REGISTER) begin
              st_nxt.regs[loc[1:0]] = cmd[7:0];
              st_nxt.std_pend = 1'b1;
            end
          end else if (cmd[15:14] == PFX_WRITE_BAD) begin
            st_nxt.reply = SYNTAX_REPLY;
          end else if (cmd[1:0] == TRL_DIAG) begin
            st_nxt.std_pend = 1'b1;
          end else if (cmd[15:14] == PFX_READ && cmd[1:0] == TRL_READ) begin
            if (loc[2]) begin
              st_nxt.reply = {PFX_WRITE, cmd[13:8], rd_val};
            end
          end else begin
            st_nxt.reply = SYNTAX_REPLY;
          end
        end
      end
      default: begin
        st_nxt.st = ST_IDLE;
        st_nxt.oe = 1'b0;
      end
    endcase

    // Software reset outranks a frame ending in the same cycle
    if (soft_reset) begin
      st_nxt.rst_pend = 1'b1;
      st_nxt.transfer_error_flag = 1'b1;
      st_nxt.regs = {RST_MAP1, RST_MAP0, RST_OUT};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r.st <= ST_IDLE;
      st_r.sclk_q <= PIN_RST[PIN_SCLK];
      st_r.cs_q <= PIN_RST[PIN_CS];
      st_r.sr <= '0;
      st_r.si_smp <= 1'b0;
      st_r.bit_lo <= 3'h0;
      st_r.bytes <= 2'h0;
      st_r.rst_pend <= 1'b1;
      st_r.std_pend <= 1'b0;
      st_r.transfer_error_flag <= 1'b1;
      st_r.reply <= SYNTAX_REPLY;
      st_r.regs <= {RST_MAP1, RST_MAP0, RST_OUT};
      st_r.so <= 1'b0;
      st_r.oe <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign so_out = st_r.so;
  assign so_oe = st_r.oe;
  // Registers leave in struct order: output control, then the two input maps
  assign ctrl = {st_r.regs[SLOT_OUT], st_r.regs[SLOT_MAP0],
                 st_r.regs[SLOT_MAP1]};

endmodule : scf_slave
`default_nettype wire

// >>> tb/scf_sva.sv
// Port-level assertions for the command frame slave
`timescale 1ns/1ns
`default_nettype none
module scf_sva
  import scf_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire scf_pins_t pins,
  input wire logic soft_reset,
  input wire logic so_out,
  input wire logic so_oe,
  input wire scf_ctrl_t ctrl
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  wire logic cs = pins.chip_select_low;
  // Eight settled cycles clear the pin filter latency of about five
  a_oe_idle: assert property (cs [*8] |-> !so_oe) else $error("serial out driven while deselected");
  a_oe_on: assert property ($fell(cs) |-> ##[1:8] so_oe) else $error("serial out not enabled");
  a_oe_off: assert property ($rose(cs) |-> ##[1:8] !so_oe) else $error("serial out not released");
  a_oe_rise: assert property ($rose(so_oe) |-> !cs) else $error("enable rose while deselected");
  a_oe_fall: assert property ($fell(so_oe) |-> cs) else $error("enable fell while selected");
  a_so_hold: assert property ((!cs && !pins.sclk) [*8] |=> $stable(so_out))
    else $error("serial out moved without clock rise");
  a_ctrl_frame: assert property ((!cs && !soft_reset) [*8] |=> $stable(ctrl))
    else $error("register changed inside a frame");
  a_ctrl_soft: assert property (soft_reset |-> ##[1:4] ctrl == {RST_OUT, RST_MAP0, RST_MAP1})
    else $error("soft reset left registers");
endmodule : scf_sva
`default_nettype wire

// >>> tb/scf_master.sv
// Serial master model that shifts frames into the slave
`timescale 1ns/1ns
`default_nettype none
module scf_master
  import scf_pkg::*;
(
  input wire logic core_clk,
  input wire logic so_out,
  input wire logic so_oe,
  output var scf_pins_t pins
);
  initial pins = PIN_RST;
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt
  // Lead, lag and gap sit well past the 200 ns and 250 ns minima
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    pins.chip_select_low <= 1'b0;
    wt(30);
    for (int i = n - 1; i >= 0; i--) begin
      pins.sclk <= 1'b1;
      pins.si <= tx[i];
      wt(10);
      // A released line has no pull, so it reads as the inverse of the last bit
      rx = {rx[30:0], so_oe ? so_out : ~so_out};
      pins.sclk <= 1'b0;
      wt(10);
    end
    wt(20);
    pins.si <= 1'b0;
    wt(10);
    pins.chip_select_low <= 1'b1;
    wt(40);
  endtask : xfer
endmodule : scf_master
`default_nettype wire

// >>> tb/scf_slave_tb.sv
// Self-checking bench for the command frame slave
`timescale 1ns/1ns
`default_nettype none
module scf_slave_tb
  import scf_pkg::*;
;
  localparam logic [15:0] RST_REPLY = {2'h2, BANK_MAP, IDX_INPUT_STATUS_REGISTER, 1'b1, 7'h55};
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic soft_reset = 1'b0;
  scf_diag_t diag = 13'h0A5C;
  logic [6:0] input_status = 7'h55;
  scf_pins_t pins;
  logic so_out;
  logic so_oe;
  scf_ctrl_t ctrl;
  int err_count = 0;
  int check_count = 0;
  logic [15:0] nxt;
  logic [31:0] rx;
  scf_slave u_dut (.core_clk(core_clk), .reset_n(reset_n), .pins(pins), .soft_reset(soft_reset), .diag(diag),
    .input_status(input_status), .so_out(so_out), .so_oe(so_oe), .ctrl(ctrl));
  scf_master u_mst (.core_clk(core_clk), .so_out(so_out), .so_oe(so_oe), .pins(pins));
  function automatic logic [15:0] sd(input logic transfer_error_flag);
    return {1'b0, diag.uv_supply, diag.low_logic_supply, diag.mode, transfer_error_flag, 1'b0, diag.open_load_off, diag.chan_err};
  endfunction : sd
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Each frame returns the answer owed by the frame before it
  task automatic fr(input logic [15:0] cmd, input logic [15:0] after);
    u_mst.xfer(16, {16'h0000, cmd}, rx);
    chk(rx[15:0], nxt);
    nxt = after;
  endtask : fr
  task automatic t_basic;
    nxt = RST_REPLY;
    fr(16'h8012, sd(1'b0));
    chk({8'h00, ctrl.out_ctrl}, 16'h0012);
    fr(16'h4002, {2'h2, BANK_OUT, IDX_OUT, 8'h12});
    fr(16'h8533, sd(1'b0));
    fr(16'h4502, {2'h2, BANK_MAP, IDX_MAP1, 8'h33});
    fr(16'h8444, sd(1'b0));
    chk({8'h00, ctrl.map_in0}, 16'h0044);
    fr(16'h4402, {2'h2, BANK_MAP, IDX_MAP0, 8'h44});
    fr(16'h4602, {2'h2, BANK_MAP, IDX_INPUT_STATUS_REGISTER, 1'b0, 7'h55});
    fr(16'h0001, sd(1'b0));
  endtask : t_basic
  task automatic t_len;
    int lens[3] = '{8, 15, 20};
    foreach (lens[i]) begin
      u_mst.xfer(lens[i], 32'h000080FF, rx);
      nxt = sd(1'b1);
      fr(16'h0001, sd(1'b0));
    end
    chk({8'h00, ctrl.out_ctrl}, 16'h0012);
    u_mst.xfer(24, 32'h00A50001, rx);
    chk(rx[23:8], nxt);
    chk({8'h00, rx[7:0]}, 16'h00A5);
    nxt = sd(1'b0);
  endtask : t_len
  task automatic t_syn;
    logic [15:0] cmds[4] = '{16'hC0FF, 16'h0002, 16'h4C02, 16'h8612};
    foreach (cmds[i]) fr(cmds[i], SYNTAX_REPLY);
    fr(16'h0001, sd(1'b0));
    chk({8'h00, ctrl.out_ctrl}, 16'h0012);
  endtask : t_syn
  task automatic t_soft;
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({ctrl.out_ctrl, ctrl.map_in1}, {RST_OUT, RST_MAP1});
    chk({8'h00, ctrl.map_in0}, {8'h00, RST_MAP0});
    nxt = RST_REPLY;
    fr(16'h0001, sd(1'b0));
  endtask : t_soft
  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // Some twenty frames of about 420 cycles each fit well inside this span
  initial begin
    #500000;
    err_count++;
    give_verdict;
  end
  initial begin
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_basic;
    t_len;
    t_syn;
    t_soft;
    fr(16'h0001, sd(1'b0));
    give_verdict;
  end
endmodule : scf_slave_tb
bind scf_slave scf_sva u_sva (.core_clk(core_clk), .reset_n(reset_n), .pins(pins), .soft_reset(soft_reset),
  .so_out(so_out), .so_oe(so_oe), .ctrl(ctrl));
`default_nettype wire
